// ---- rtl/ic_seq_consts.svh ----
// Constants for the microinstruction sequencer: addresses, resets, ranges.
// Assumes a 16-bit control-store address and 24-bit control-store words.
//
// Summary of operation
// - Power-up forces microtrap to address 8003.
// - Selector loads trap address; counter then increments.
// - Subroutine branch pushes incremented counter first.
// - Program counter pair clears or sets ones.
// - Low and high bytes load separately.
// - Bad parity traps to 8000, address kept.
// - Trap decoder forces addresses 8005 to 800E.
// - Store access address comes from stack.
// - Write then read returns same 24 bits.
// - Increment carries across every counter bit.
// - Branch at 0010 pushes 0011 for return.
// - Select decodes 3FFF or 4FFF RAM top.
// - Address below failing one is recoverable.
`ifndef IC_SEQ_CONSTS_SVH
`define IC_SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// Trap addresses
// ----------------------------------------------------------------
`define TRAP_POWER_ON 16'h8003
`define TRAP_PARITY 16'h8000
`define TRAP_BASE 16'h8000
`define TRAP_IDX_MIN 4'h5
`define TRAP_IDX_MAX 4'hE

// ----------------------------------------------------------------
// Reset values and memory map
// ----------------------------------------------------------------
`define IC_RESET 16'h0000
`define PC_BYTE_ZERO 8'h00
`define PC_BYTE_ONES 8'hFF
`define CM_TOP_16K 16'h3FFF
`define CM_TOP_20K 16'h4FFF
`define PROM_BASE 16'h8000

`endif

// ---- rtl/ic_seq_pkg.sv ----
// Types shared by the sequencer and its counter source selector.
// Assumes the constants header is included by the design files.
package ic_seq_pkg;

    // Microinstruction operations seen by the sequencer
    typedef enum logic [3:0] {
        OP_NEXT,
        OP_BRANCH,
        OP_SUB_BRANCH,
        OP_RETURN,
        OP_PC_CLEAR,
        OP_PC_ONES,
        OP_PC_LOAD_LOW,
        OP_PC_LOAD_HIGH,
        OP_WRITE_CS,
        OP_READ_CS
    } op_e;

    // Source chosen for the next fetch address
    typedef enum logic [2:0] {
        SRC_POWER_ON,
        SRC_PARITY,
        SRC_TRAP,
        SRC_JUMP,
        SRC_INCREMENT
    } src_e;

    // Decoded microinstruction for the word at the current counter
    typedef struct packed {
        op_e op;
        logic [15:0] target;
        logic [7:0] byte_val;
        logic [23:0] wdata;
    } micro_cmd_s;

    // Control-store access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic ram_sel;
        logic prom_sel;
        logic [15:0] addr;
        logic [23:0] wdata;
    } cm_req_s;

endpackage

// ---- rtl/counter_source_selector.sv ----
// Counter source selector: picks the next fetch address by priority.
// Assumes one-cycle microinstructions and a decoded trap index input.
`timescale 1ns/1ns
`include "ic_seq_consts.svh"

module counter_source_selector (
    input wire logic por_pending, // Power-on trap still to be taken
    input wire logic parity_err, // Fetched word had bad parity
    input wire logic trap_valid, // Trap decoder requests a trap
    input wire logic [3:0] trap_index, // Trap decoder address low nibble
    input wire logic jump, // Branch, subroutine branch or return
    input wire logic [15:0] jump_addr, // Target of the jump
    input wire logic [15:0] ic_inc, // Incremented counter value
    output logic [15:0] next_addr, // Selected next fetch address
    output ic_seq_pkg::src_e src // Which source won
);

    // ----------------------------------------------------------------
    // Trap index check, used only by the priority mux below
    // ----------------------------------------------------------------
    function automatic logic trap_in_range(input logic [3:0] idx);
        trap_in_range = (idx >= `TRAP_IDX_MIN) && (idx <= `TRAP_IDX_MAX);
    endfunction

    // Priority mux: power-on, parity, decoder trap, jump, increment
    always_comb begin
        next_addr = ic_inc;
        src = ic_seq_pkg::SRC_INCREMENT;
        if (por_pending) begin
            next_addr = `TRAP_POWER_ON;
            src = ic_seq_pkg::SRC_POWER_ON;
        end else if (parity_err) begin
            next_addr = `TRAP_PARITY;
            src = ic_seq_pkg::SRC_PARITY;
        end else if (trap_valid && trap_in_range(trap_index)) begin
            next_addr = `TRAP_BASE | {12'h000, trap_index};
            src = ic_seq_pkg::SRC_TRAP;
        end else if (jump) begin
            next_addr = jump_addr;
            src = ic_seq_pkg::SRC_JUMP;
        end
    end

endmodule

// ---- rtl/instruction_counter_sequencer.sv ----
// Microinstruction sequencer: counter, program counter pair, store access.
// Assumes an external return stack and control store on the same clock.
`timescale 1ns/1ns
`include "ic_seq_consts.svh"

module instruction_counter_sequencer #(
    parameter int ADDR_W = 16, // Control-store address width
    parameter int DATA_W = 24 // Control-store word width
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic reset_n, // Asynchronous power-on reset, low
    input wire ic_seq_pkg::micro_cmd_s cmd, // Decoded word at the counter
    input wire logic parity_err, // Bad parity on the word at the counter
    input wire logic trap_valid, // Trap decoder request
    input wire logic [3:0] trap_index, // Trap decoder address nibble
    input wire logic size_20k, // Control memory is 20K, else 16K
    input wire logic [15:0] stack_top, // Top entry of the return stack
    input wire logic [23:0] cm_rdata, // Data read from control store
    output logic [15:0] instruction_counter, // Current fetch address
    output logic stack_push, // Push pulse to return stack
    output logic [15:0] stack_push_data, // Value pushed
    output logic stack_pop, // Pop pulse to return stack
    output ic_seq_pkg::cm_req_s cm_req, // Control-store access
    output logic [23:0] cm_read_data, // Captured read data
    output logic [7:0] pc_low_byte, // Program counter low byte
    output logic [7:0] pc_high_byte, // Program counter high byte
    output logic [15:0] fail_addr, // Address that gave bad parity
    output logic [15:0] last_good_addr, // Address before the failing one
    output logic parity_trapped // A parity trap has been taken
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W != 16) begin : g_bad_addr
        $error("ADDR_W must be 16");
    end
    if (DATA_W != 24) begin : g_bad_data
        $error("DATA_W must be 24");
    end

    // Range check for store selects, used for reads and writes
    function automatic logic ram_hit(input logic [15:0] a, input logic big);
        ram_hit = big ? (a <= `CM_TOP_20K) : (a <= `CM_TOP_16K);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic por_pending_r, por_pending_nxt; // Power-on trap not yet taken
    logic [15:0] ic_r, ic_nxt; // Instruction counter
    logic [7:0] pcl_r, pcl_nxt; // Program counter low byte
    logic [7:0] pch_r, pch_nxt; // Program counter high byte
    logic push_r, push_nxt; // Push strobe
    logic [15:0] push_data_r, push_data_nxt; // Push value
    logic pop_r, pop_nxt; // Pop strobe
    ic_seq_pkg::cm_req_s cm_r, cm_nxt; // Store request
    logic rd_wait_r, rd_wait_nxt; // Read data due this cycle
    logic [23:0] rdata_r, rdata_nxt; // Captured read data
    logic [15:0] fail_r, fail_nxt; // Failing address
    logic [15:0] good_r, good_nxt; // Last good address
    logic ptrap_r, ptrap_nxt; // Parity trap taken flag

    logic [15:0] ic_inc; // Counter plus one
    logic jump; // Word redirects the flow
    logic [15:0] jump_addr; // Where it redirects to
    logic [15:0] sel_addr; // Selector output
    ic_seq_pkg::src_e sel_src; // Selector winner
    logic exec_ok; // Current word may take effect

    // Full-width add so the carry ripples through all bits
    assign ic_inc = ic_r + 16'h0001;
    assign exec_ok = !por_pending_r && !parity_err;

    // Jump decode for branches, subroutine branches and returns
    always_comb begin
        jump = 1'b0;
        jump_addr = cmd.target;
        case (cmd.op)
            ic_seq_pkg::OP_BRANCH: jump = 1'b1;
            ic_seq_pkg::OP_SUB_BRANCH: jump = 1'b1;
            ic_seq_pkg::OP_RETURN: begin
                jump = 1'b1;
                jump_addr = stack_top;
            end
            default: jump = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Counter source selection
    // ----------------------------------------------------------------
    counter_source_selector u_sel (
        .por_pending(por_pending_r),
        .parity_err(parity_err),
        .trap_valid(trap_valid),
        .trap_index(trap_index),
        .jump(jump),
        .jump_addr(jump_addr),
        .ic_inc(ic_inc),
        .next_addr(sel_addr),
        .src(sel_src)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        por_pending_nxt = 1'b0; // Cleared once the trap is taken
        ic_nxt = sel_addr;
        pcl_nxt = pcl_r;
        pch_nxt = pch_r;
        push_nxt = 1'b0;
        push_data_nxt = push_data_r;
        pop_nxt = 1'b0;
        cm_nxt = cm_r;
        cm_nxt.rd = 1'b0;
        cm_nxt.wr = 1'b0;
        rd_wait_nxt = 1'b0;
        rdata_nxt = rd_wait_r ? cm_rdata : rdata_r;
        fail_nxt = fail_r;
        good_nxt = good_r;
        ptrap_nxt = ptrap_r;
        // Parity trap keeps the failing address and the one below it
        if (!por_pending_r && parity_err) begin
            fail_nxt = ic_r;
            good_nxt = ic_r - 16'h0001;
            ptrap_nxt = 1'b1;
        end
        if (exec_ok) begin
            case (cmd.op)
                ic_seq_pkg::OP_SUB_BRANCH: begin
                    push_nxt = 1'b1;
                    push_data_nxt = ic_inc;
                end
                ic_seq_pkg::OP_RETURN: pop_nxt = 1'b1;
                ic_seq_pkg::OP_PC_CLEAR: begin
                    pcl_nxt = `PC_BYTE_ZERO;
                    pch_nxt = `PC_BYTE_ZERO;
                end
                ic_seq_pkg::OP_PC_ONES: begin
                    pcl_nxt = `PC_BYTE_ONES;
                    pch_nxt = `PC_BYTE_ONES;
                end
                ic_seq_pkg::OP_PC_LOAD_LOW: pcl_nxt = cmd.byte_val;
                ic_seq_pkg::OP_PC_LOAD_HIGH: pch_nxt = cmd.byte_val;
                ic_seq_pkg::OP_WRITE_CS, ic_seq_pkg::OP_READ_CS: begin
                    // Address from the stack, RAM select decoded by size
                    cm_nxt.addr = stack_top;
                    cm_nxt.wdata = cmd.wdata;
                    cm_nxt.ram_sel = ram_hit(stack_top, size_20k);
                    cm_nxt.prom_sel = stack_top >= `PROM_BASE;
                    if (cmd.op == ic_seq_pkg::OP_WRITE_CS) begin
                        // Only RAM is writable; holes drop the write
                        cm_nxt.wr = ram_hit(stack_top, size_20k);
                    end else begin
                        cm_nxt.rd = 1'b1;
                        rd_wait_nxt = 1'b1;
                    end
                end
                default: push_nxt = 1'b0; // Sequencing only
            endcase
        end
    end

    // Register stage for all sequencer state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_pending_r <= 1'b1;
            ic_r <= `IC_RESET;
            pcl_r <= `PC_BYTE_ZERO;
            pch_r <= `PC_BYTE_ZERO;
            push_r <= 1'b0;
            push_data_r <= 16'h0000;
            pop_r <= 1'b0;
            cm_r <= '0;
            rd_wait_r <= 1'b0;
            rdata_r <= 24'h000000;
            fail_r <= 16'h0000;
            good_r <= 16'h0000;
            ptrap_r <= 1'b0;
        end else begin
            por_pending_r <= por_pending_nxt;
            ic_r <= ic_nxt;
            pcl_r <= pcl_nxt;
            pch_r <= pch_nxt;
            push_r <= push_nxt;
            push_data_r <= push_data_nxt;
            pop_r <= pop_nxt;
            cm_r <= cm_nxt;
            rd_wait_r <= rd_wait_nxt;
            rdata_r <= rdata_nxt;
            fail_r <= fail_nxt;
            good_r <= good_nxt;
            ptrap_r <= ptrap_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign instruction_counter = ic_r;
    assign stack_push = push_r;
    assign stack_push_data = push_data_r;
    assign stack_pop = pop_r;
    assign cm_req = cm_r;
    assign cm_read_data = rdata_r;
    assign pc_low_byte = pcl_r;
    assign pc_high_byte = pch_r;
    assign fail_addr = fail_r;
    assign last_good_addr = good_r;
    assign parity_trapped = ptrap_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_sub_branch;
        !por_pending_r && !parity_err && cmd.op == ic_seq_pkg::OP_SUB_BRANCH;
    endsequence

    chk_power_on_trap: assert property (
        por_pending_r |=> ic_r == 16'h8003 && !por_pending_r)
        else $error("power-on trap not taken to 8003");
    chk_trap_then_inc: assert property (
        $past(por_pending_r) && !por_pending_r && !parity_err && !trap_valid && !jump
        |=> ic_r == 16'h8004)
        else $error("counter did not step past power-on trap");
    chk_push_incr: assert property (
        s_sub_branch |=> stack_push && stack_push_data == $past(ic_r) + 16'h0001
        && ic_r == $past(cmd.target))
        else $error("subroutine branch push or target wrong");
    chk_pc_clear: assert property (
        !por_pending_r && !parity_err && cmd.op == ic_seq_pkg::OP_PC_CLEAR
        |=> {pc_high_byte, pc_low_byte} == 16'h0000)
        else $error("program counter pair not cleared");
    chk_pc_low_load: assert property (
        !por_pending_r && !parity_err && cmd.op == ic_seq_pkg::OP_PC_LOAD_LOW
        |=> pc_low_byte == $past(cmd.byte_val) && $stable(pc_high_byte))
        else $error("low byte load disturbed or missed");
    chk_parity_trap: assert property (
        !por_pending_r && parity_err
        |=> ic_r == 16'h8000 && fail_addr == $past(ic_r) && parity_trapped)
        else $error("parity trap address or capture wrong");
    chk_good_addr: assert property (
        parity_trapped |-> last_good_addr == fail_addr - 16'h0001)
        else $error("last good address not one below failing");
    chk_decoder_trap: assert property (
        !por_pending_r && !parity_err && trap_valid
        && trap_index >= 4'h5 && trap_index <= 4'hE
        |=> ic_r == {12'h800, $past(trap_index)})
        else $error("decoder trap address wrong");
    chk_ripple_inc: assert property (
        sel_src == ic_seq_pkg::SRC_INCREMENT |=> ic_r == $past(ic_r) + 16'h0001)
        else $error("sequential increment wrong");
    chk_cs_select: assert property (
        cm_req.wr |-> cm_req.addr <= (size_20k ? 16'h4FFF : 16'h3FFF))
        else $error("write outside decoded control memory");
    chk_read_data: assert property (
        cm_req.rd |=> cm_read_data == $past(cm_rdata))
        else $error("read data not captured");

endmodule

// ---- testbench/cs_stack_model.sv ----
// Behavioural control store and return stack on the sequencer's far side.
// Assumes one clock; the bench may push an address to set the store pointer.
`timescale 1ns/1ns

module cs_stack_model (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, low
    input wire ic_seq_pkg::cm_req_s cm_req, // Store access from the sequencer
    input wire logic stack_push, // Push pulse from the sequencer
    input wire logic [15:0] stack_push_data, // Value pushed
    input wire logic stack_pop, // Pop pulse from the sequencer
    input wire logic preload, // Bench pushes an address
    input wire logic [15:0] preload_val, // Address pushed by the bench
    output logic [15:0] stack_top, // Top entry of the stack
    output logic [23:0] cm_rdata // Store read data
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [23:0] mem_r [0:32767]; // Store words for the lower 32K addresses only
    logic [15:0] stk_r [0:63]; // Stack entries
    logic [5:0] sp_r; // Entries held
    logic [23:0] last_r; // Last value on the read lines

    // Read data only while a read is requested, else a changing pattern
    always_comb begin
        if (cm_req.rd) begin
            cm_rdata = mem_r[cm_req.addr[14:0]];
        end else begin
            cm_rdata = ~last_r;
        end
        stack_top = (sp_r == 6'h00) ? ~last_r[15:0] : stk_r[sp_r - 6'h01];
    end

    // Writes, stack moves and pattern update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_r <= 6'h00;
            last_r <= 24'h000000;
        end else begin
            last_r <= cm_rdata;
            if (cm_req.wr) begin
                mem_r[cm_req.addr[14:0]] <= cm_req.wdata;
            end
            if (stack_push || preload) begin
                stk_r[sp_r] <= stack_push ? stack_push_data : preload_val;
                sp_r <= sp_r + 6'h01;
            end else if (stack_pop && sp_r != 6'h00) begin
                sp_r <= sp_r - 6'h01;
            end
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the microinstruction sequencer.
// Assumes the store/stack model answers the sequencer's far side.
`timescale 1ns/1ns

module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, reset_n, parity_err, trap_valid, size_20k, preload; // Bench inputs
    logic [3:0] trap_index; // Trap nibble
    logic [15:0] stack_top, preload_val, ic, push_data, fail_addr, last_good; // Addresses
    logic [23:0] cm_rdata, rd_data; // Store data
    logic push, pop, trapped; // Pulses and flags
    logic [7:0] pc_lo, pc_hi; // Program counter pair
    ic_seq_pkg::micro_cmd_s cmd; // Word at the counter
    ic_seq_pkg::cm_req_s cm_req_w; // Store request
    int err_count, num_checks, seed; // Tallies and random seed
    logic [15:0] a, prev; // Scratch addresses
    logic [23:0] d; // Scratch data
    logic [15:0] addrs [0:7]; // Corner store addresses

    instruction_counter_sequencer dut_u (.clk(clk), .reset_n(reset_n), .cmd(cmd),
        .parity_err(parity_err), .trap_valid(trap_valid), .trap_index(trap_index),
        .size_20k(size_20k), .stack_top(stack_top), .cm_rdata(cm_rdata),
        .instruction_counter(ic), .stack_push(push), .stack_push_data(push_data),
        .stack_pop(pop), .cm_req(cm_req_w), .cm_read_data(rd_data), .pc_low_byte(pc_lo),
        .pc_high_byte(pc_hi), .fail_addr(fail_addr), .last_good_addr(last_good),
        .parity_trapped(trapped));

    cs_stack_model model_u (.clk(clk), .reset_n(reset_n), .cm_req(cm_req_w),
        .stack_push(push), .stack_push_data(push_data), .stack_pop(pop),
        .preload(preload), .preload_val(preload_val), .stack_top(stack_top),
        .cm_rdata(cm_rdata));

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One clock; inputs change 1 ns after the edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // Present one microinstruction for one edge
    task automatic run(input ic_seq_pkg::op_e op, input logic [15:0] tgt,
                       input logic [7:0] bv, input logic [23:0] wd);
        cmd.op = op;
        cmd.target = tgt;
        cmd.byte_val = bv;
        cmd.wdata = wd;
        tick();
        cmd.op = ic_seq_pkg::OP_NEXT;
    endtask

    // Reset held 16 cycles, then the power-on trap
    task automatic do_reset;
        reset_n = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        check(24'(ic), 24'h000000);
        reset_n = 1'b1;
        tick();
        check(24'(ic), 24'h008003);
        run(ic_seq_pkg::OP_NEXT, 16'h0000, 8'h00, 24'h000000);
        check(24'(ic), 24'h008004);
        check(24'(trapped), 24'h000000);
    endtask

    // Store write through the stack address, then a read back only when it hits RAM
    task automatic access(input logic [15:0] ad, input logic [23:0] dat, input logic big);
        logic ok;
        ok = (ad <= (big ? 16'h4FFF : 16'h3FFF));
        size_20k = big;
        preload = 1'b1;
        preload_val = ad;
        tick();
        preload = 1'b0;
        run(ic_seq_pkg::OP_WRITE_CS, 16'h0000, 8'h00, dat);
        check(24'(cm_req_w.wr), 24'(ok));
        check(24'(cm_req_w.addr), 24'(ad));
        check(24'(cm_req_w.ram_sel), 24'(ok));
        check(24'(cm_req_w.prom_sel), 24'(ad >= 16'h8000));
        check(cm_req_w.wdata, dat);
        if (ok) begin
            run(ic_seq_pkg::OP_READ_CS, 16'h0000, 8'h00, 24'h000000);
            check(24'(cm_req_w.rd), 24'h000001);
            check(24'(cm_req_w.addr), 24'(ad));
            tick();
            check(rd_data, dat);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, far beyond the several hundred cycles the tests take
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 24;
        err_count = 0;
        num_checks = 0;
        reset_n = 1'b0;
        parity_err = 1'b0;
        trap_valid = 1'b0;
        trap_index = 4'h0;
        size_20k = 1'b0;
        preload = 1'b0;
        preload_val = 16'h0000;
        cmd = '0;
        addrs = '{16'h0FFF, 16'h1FFF, 16'h2FFF, 16'h3FFF, 16'h4FFF, 16'h4FFF, 16'h5000, 16'h8005};
        do_reset();
        $display("test power_on done");
        // Every decoder index, legal ones trap, others fall through
        for (int i = 0; i < 16; i++) begin
            prev = ic;
            trap_valid = 1'b1;
            trap_index = 4'(i);
            tick();
            trap_valid = 1'b0;
            check(24'(ic), (i >= 5 && i <= 14) ? 24'(16'h8000 | 16'(i)) : 24'(prev + 16'h0001));
        end
        $display("test traps done");
        run(ic_seq_pkg::OP_PC_CLEAR, 16'h0000, 8'h00, 24'h000000);
        check(24'({pc_hi, pc_lo}), 24'h000000);
        run(ic_seq_pkg::OP_PC_ONES, 16'h0000, 8'h00, 24'h000000);
        check(24'({pc_hi, pc_lo}), 24'h00FFFF);
        // Every byte value through both halves, high half walking down
        for (int k = 0; k < 256; k++) begin
            d = {8'h00, 8'(255 - k), 8'(k)};
            prev = {pc_hi, pc_lo};
            run(ic_seq_pkg::OP_PC_LOAD_LOW, 16'h0000, d[7:0], 24'h000000);
            check(24'({pc_hi, pc_lo}), 24'({prev[15:8], d[7:0]}));
            run(ic_seq_pkg::OP_PC_LOAD_HIGH, 16'h0000, d[15:8], 24'h000000);
            check(24'({pc_hi, pc_lo}), 24'({d[15:8], d[7:0]}));
        end
        $display("test program_counter done");
        // Carry corners then random starts, each followed by a call and return
        for (int k = 0; k < 10; k++) begin
            a = (k == 0) ? 16'h000F : (k == 1) ? 16'h00FF : (k == 2) ? 16'h0FFF
                : (16'($random(seed)) & 16'h3FFF);
            run(ic_seq_pkg::OP_BRANCH, a, 8'h00, 24'h000000);
            check(24'(ic), 24'(a));
            run(ic_seq_pkg::OP_NEXT, 16'h0000, 8'h00, 24'h000000);
            check(24'(ic), 24'(a + 16'h0001));
            run(ic_seq_pkg::OP_SUB_BRANCH, 16'h8023, 8'h00, 24'h000000);
            check(24'(ic), 24'h008023);
            check(24'(push), 24'h000001);
            check(24'(push_data), 24'(a + 16'h0002));
            run(ic_seq_pkg::OP_NEXT, 16'h0000, 8'h00, 24'h000000);
            check(24'(push), 24'h000000);
            run(ic_seq_pkg::OP_RETURN, 16'h0000, 8'h00, 24'h000000);
            check(24'(ic), 24'(a + 16'h0002));
            check(24'(pop), 24'h000001);
        end
        $display("test call_return done");
        for (int k = 0; k < 8; k++) begin
            access(addrs[k], 24'hD5AA55, k == 5 || k == 6);
        end
        for (int k = 0; k < 12; k++) begin
            access(16'($random(seed)) & 16'h3FFF, 24'($random(seed)), 1'b0);
        end
        $display("test control_store done");
        // Parity beats a decoder trap and a call in the same cycle
        run(ic_seq_pkg::OP_BRANCH, 16'h0123, 8'h00, 24'h000000);
        parity_err = 1'b1;
        trap_valid = 1'b1;
        trap_index = 4'h6;
        run(ic_seq_pkg::OP_SUB_BRANCH, 16'h8023, 8'h00, 24'h000000);
        parity_err = 1'b0;
        trap_valid = 1'b0;
        check(24'(ic), 24'h008000);
        check(24'(push), 24'h000000);
        check(24'(fail_addr), 24'h000123);
        check(24'(last_good), 24'h000122);
        check(24'(trapped), 24'h000001);
        // Trap flag and capture hold while execution resumes past 8000
        run(ic_seq_pkg::OP_NEXT, 16'h0000, 8'h00, 24'h000000);
        check(24'(ic), 24'h008001);
        check(24'(trapped), 24'h000001);
        check(24'(fail_addr), 24'h000123);
        check(24'(last_good), 24'h000122);
        $display("test parity done");
        do_reset();
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
